// >>> hw/dma_ctrl_pkg.sv
// Shared constants for the DMA software request and interrupt mask block
package dma_ctrl_pkg;
   localparam int unsigned NUM_CH      = 6;
   localparam int unsigned REQ_W       = 2 * NUM_CH;
   localparam int unsigned ADDR_W      = 32;
   localparam int unsigned DATA_W      = 32;

   // Register byte addresses
   localparam logic [31:0] CONTROLLER_ENABLE_ADDR = 32'h400C_4004;
   localparam logic [31:0] SW_SINGLE_REQUEST_ADDR = 32'h400C_4008;
   localparam logic [31:0] SW_CHUNK_REQUEST_ADDR  = 32'h400C_400C;
   localparam logic [31:0] SW_FINAL_FLAG_ADDR     = 32'h400C_4010;
   localparam logic [31:0] IRQ_ENABLE_SET_ADDR    = 32'h400C_4018;
   localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR  = 32'h400C_401C;
   localparam logic [31:0] IRQ_MASK_VIEW_ADDR     = 32'h400C_4020;
   localparam logic [31:0] IRQ_EVENT_STATUS_ADDR  = 32'h400C_4024;

   // Field positions
   localparam int unsigned ENABLE_BIT     = 0;
   localparam int unsigned BUF_DONE_LSB   = 0;
   localparam int unsigned CHAIN_DONE_LSB = 8;
   localparam int unsigned BUS_FAULT_LSB  = 16;

   // Reset values
   localparam logic        CONTROLLER_ENABLE_RST = 1'h0;
   localparam logic [11:0] REQUEST_RST           = 12'h000;
   localparam logic [11:0] FINAL_FLAG_RST        = 12'h000;
   localparam logic [5:0]  MASK_RST              = 6'h00;
   localparam logic [5:0]  STATUS_RST            = 6'h00;
   localparam logic [31:0] RDATA_RST             = 32'h0000_0000;
endpackage

// >>> hw/dma_sw_request_irq_ctrl.sv
// Software request, final-transfer marker and interrupt mask registers of a six-channel DMA
// Operation
// - Enable register bit 0 turns the single and chunk request outputs off (0) or on (1); resets zero.
// - Writes to the enable register are ignored while write protection is on.
// - Writing one to single request bit 2i+1 requests a destination single transfer.
// - Writing one to single request bit 2i requests a source single transfer.
// - Writing one to chunk request bit 2i+1 requests a destination chunk transfer.
// - Writing one to chunk request bit 2i requests a source chunk transfer.
// - Destination final bit set before a destination request marks that request last.
// - Source final bit set before a source request marks that request last.
// - Enable register bits 5:0 set the buffer-done mask bits.
// - Enable register bits 13:8 set the chain-done mask bits.
// - Enable register bits 21:16 set the bus-fault mask bits.
// - Disable register ones clear matching mask bits, same layout as enable.
// - Mask view register is read-only, same layout, resets to zero.
// - Mask bit one means that interrupt is enabled, zero disabled.
// - A channel's bus error response sets its bus-fault status bit.
//
// The implementer's own choice: the strobed register port.
module dma_sw_request_irq_ctrl (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic        i_write_protect_on,
   output logic             o_controller_enable,
   output logic      [11:0] o_single_req,
   output logic      [11:0] o_burst_req,
   output logic      [11:0] o_final_mark,
   input  wire logic [11:0] i_single_ack,
   input  wire logic [11:0] i_burst_ack,
   input  wire logic [5:0]  i_buffer_done_evt,
   input  wire logic [5:0]  i_chain_done_evt,
   input  wire logic [5:0]  i_bus_fault_evt,
   output logic             o_irq
);

   // Place the three per-channel event fields in a bus word
   function automatic logic [31:0] pack_events(input logic [5:0] buf_done,
                                               input logic [5:0] chain_done,
                                               input logic [5:0] bus_fault);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[dma_ctrl_pkg::BUF_DONE_LSB   +: 6] = buf_done;
      word[dma_ctrl_pkg::CHAIN_DONE_LSB +: 6] = chain_done;
      word[dma_ctrl_pkg::BUS_FAULT_LSB  +: 6] = bus_fault;
      return word;
   endfunction

   // Set-over-clear update for a sticky bit vector
   function automatic logic [11:0] set_clear(input logic [11:0] cur,
                                             input logic [11:0] set,
                                             input logic [11:0] clr);
      return (cur & ~clr) | set;
   endfunction

   logic        controller_enable_reg;
   logic [11:0] single_pend_reg;
   logic [11:0] burst_pend_reg;
   logic [11:0] final_flag_reg;
   logic [5:0]  buf_done_mask_reg;
   logic [5:0]  chain_done_mask_reg;
   logic [5:0]  bus_fault_mask_reg;
   logic [5:0]  buf_done_stat_reg;
   logic [5:0]  chain_done_stat_reg;
   logic [5:0]  bus_fault_stat_reg;

   logic        wr_enable;
   logic        wr_single;
   logic        wr_burst;
   logic        wr_final;
   logic        wr_irq_set;
   logic        wr_irq_clr;
   logic        rd_status;
   logic [11:0] req_wbits;
   logic [11:0] consumed;
   logic [31:0] rdata_next;

   assign wr_enable  = i_wr && (i_addr == dma_ctrl_pkg::CONTROLLER_ENABLE_ADDR);
   assign wr_single  = i_wr && (i_addr == dma_ctrl_pkg::SW_SINGLE_REQUEST_ADDR);
   assign wr_burst   = i_wr && (i_addr == dma_ctrl_pkg::SW_CHUNK_REQUEST_ADDR);
   assign wr_final   = i_wr && (i_addr == dma_ctrl_pkg::SW_FINAL_FLAG_ADDR);
   assign wr_irq_set = i_wr && (i_addr == dma_ctrl_pkg::IRQ_ENABLE_SET_ADDR);
   assign wr_irq_clr = i_wr && (i_addr == dma_ctrl_pkg::IRQ_ENABLE_CLEAR_ADDR);
   assign rd_status  = i_rd && (i_addr == dma_ctrl_pkg::IRQ_EVENT_STATUS_ADDR);
   assign req_wbits  = i_wdata[11:0];
   // Ack of either kind of request consumes its final marker
   assign consumed   = (i_single_ack & single_pend_reg) | (i_burst_ack & burst_pend_reg);

   // Global enable, locked by write protection
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         controller_enable_reg <= dma_ctrl_pkg::CONTROLLER_ENABLE_RST;
      end else if (wr_enable && !i_write_protect_on) begin
         controller_enable_reg <= i_wdata[dma_ctrl_pkg::ENABLE_BIT];
      end
   end

   // Single requests: even bits source, odd bits destination
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         single_pend_reg <= dma_ctrl_pkg::REQUEST_RST;
      end else begin
         // Only ones raise a request; new request wins over an ack
         single_pend_reg <= set_clear(single_pend_reg, wr_single ? req_wbits : 12'h000,
                                      i_single_ack);
      end
   end

   // Chunk requests: even bits source, odd bits destination
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         burst_pend_reg <= dma_ctrl_pkg::REQUEST_RST;
      end else begin
         burst_pend_reg <= set_clear(burst_pend_reg, wr_burst ? req_wbits : 12'h000,
                                     i_burst_ack);
      end
   end

   // Final markers stay with the channel until its request is taken
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         final_flag_reg <= dma_ctrl_pkg::FINAL_FLAG_RST;
      end else begin
         final_flag_reg <= set_clear(final_flag_reg, wr_final ? req_wbits : 12'h000,
                                     consumed);
      end
   end

   // Interrupt mask: clear register wins over set register
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         buf_done_mask_reg   <= dma_ctrl_pkg::MASK_RST;
         chain_done_mask_reg <= dma_ctrl_pkg::MASK_RST;
         bus_fault_mask_reg  <= dma_ctrl_pkg::MASK_RST;
      end else begin
         if (wr_irq_clr) begin
            buf_done_mask_reg   <= buf_done_mask_reg   & ~i_wdata[dma_ctrl_pkg::BUF_DONE_LSB   +: 6];
            chain_done_mask_reg <= chain_done_mask_reg & ~i_wdata[dma_ctrl_pkg::CHAIN_DONE_LSB +: 6];
            bus_fault_mask_reg  <= bus_fault_mask_reg  & ~i_wdata[dma_ctrl_pkg::BUS_FAULT_LSB  +: 6];
         end else if (wr_irq_set) begin
            buf_done_mask_reg   <= buf_done_mask_reg   | i_wdata[dma_ctrl_pkg::BUF_DONE_LSB   +: 6];
            chain_done_mask_reg <= chain_done_mask_reg | i_wdata[dma_ctrl_pkg::CHAIN_DONE_LSB +: 6];
            bus_fault_mask_reg  <= bus_fault_mask_reg  | i_wdata[dma_ctrl_pkg::BUS_FAULT_LSB  +: 6];
         end
      end
   end

   // Event status: sticky, cleared by reading, a new event beats the read
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         buf_done_stat_reg   <= dma_ctrl_pkg::STATUS_RST;
         chain_done_stat_reg <= dma_ctrl_pkg::STATUS_RST;
         bus_fault_stat_reg  <= dma_ctrl_pkg::STATUS_RST;
      end else begin
         buf_done_stat_reg   <= (rd_status ? 6'h00 : buf_done_stat_reg) | i_buffer_done_evt;
         chain_done_stat_reg <= (rd_status ? 6'h00 : chain_done_stat_reg) | i_chain_done_evt;
         bus_fault_stat_reg  <= (rd_status ? 6'h00 : bus_fault_stat_reg) | i_bus_fault_evt;
      end
   end

   // Read mux; write-only and unmapped addresses read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (i_addr)
         dma_ctrl_pkg::CONTROLLER_ENABLE_ADDR: begin
            rdata_next[dma_ctrl_pkg::ENABLE_BIT] = controller_enable_reg;
         end
         dma_ctrl_pkg::SW_SINGLE_REQUEST_ADDR: begin
            rdata_next[11:0] = single_pend_reg;
         end
         dma_ctrl_pkg::SW_CHUNK_REQUEST_ADDR: begin
            rdata_next[11:0] = burst_pend_reg;
         end
         dma_ctrl_pkg::SW_FINAL_FLAG_ADDR: begin
            rdata_next[11:0] = final_flag_reg;
         end
         dma_ctrl_pkg::IRQ_MASK_VIEW_ADDR: begin
            rdata_next = pack_events(buf_done_mask_reg, chain_done_mask_reg, bus_fault_mask_reg);
         end
         dma_ctrl_pkg::IRQ_EVENT_STATUS_ADDR: begin
            rdata_next = pack_events(buf_done_stat_reg, chain_done_stat_reg, bus_fault_stat_reg);
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= dma_ctrl_pkg::RDATA_RST;
      end else begin
         o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
      end
   end

   // Requests reach the engine only while the controller is enabled
   assign o_controller_enable = controller_enable_reg;
   assign o_single_req        = single_pend_reg & {12{controller_enable_reg}};
   assign o_burst_req         = burst_pend_reg & {12{controller_enable_reg}};
   assign o_final_mark        = final_flag_reg;

   assign o_irq = |((buf_done_stat_reg   & buf_done_mask_reg)   |
                    (chain_done_stat_reg & chain_done_mask_reg) |
                    (bus_fault_stat_reg  & bus_fault_mask_reg));

endmodule

// >>> tb/dma_sw_request_irq_ctrl_asserts.sv
// Checker for the DMA request and interrupt mask block
module dma_sw_request_irq_ctrl_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_reset_n,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_write_protect_on,
   input wire logic        o_controller_enable,
   input wire logic [11:0] o_single_req,
   input wire logic [11:0] o_burst_req,
   input wire logic [11:0] o_final_mark,
   input wire logic [5:0]  i_buffer_done_evt,
   input wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);
   a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_enable_protect: assert property (i_wr && i_addr == dma_ctrl_pkg::CONTROLLER_ENABLE_ADDR && i_write_protect_on
      |=> $stable(o_controller_enable)) else $error("protected enable write took effect");
   a_enable_write: assert property (i_wr && i_addr == dma_ctrl_pkg::CONTROLLER_ENABLE_ADDR && !i_write_protect_on
      |=> o_controller_enable == $past(i_wdata[0])) else $error("enable write lost");
   a_single_set: assert property (i_wr && i_addr == dma_ctrl_pkg::SW_SINGLE_REQUEST_ADDR && o_controller_enable
      |=> (o_single_req & $past(i_wdata[11:0])) == $past(i_wdata[11:0])) else $error("single request missing");
   a_burst_set: assert property (i_wr && i_addr == dma_ctrl_pkg::SW_CHUNK_REQUEST_ADDR && o_controller_enable
      |=> (o_burst_req & $past(i_wdata[11:0])) == $past(i_wdata[11:0])) else $error("chunk request missing");
   a_final_set: assert property (i_wr && i_addr == dma_ctrl_pkg::SW_FINAL_FLAG_ADDR
      |=> (o_final_mark & $past(i_wdata[11:0])) == $past(i_wdata[11:0])) else $error("final mark missing");
   a_req_gated: assert property (!o_controller_enable |-> (o_single_req | o_burst_req) == 12'h000)
      else $error("request shown while disabled");
   a_mask_irq: assert property (i_wr && i_addr == dma_ctrl_pkg::IRQ_ENABLE_SET_ADDR
      && (i_wdata[5:0] & i_buffer_done_evt) != 6'h00 |=> o_irq) else $error("enabled event gave no interrupt");
   a_clear_quiet: assert property (i_wr && i_addr == dma_ctrl_pkg::IRQ_ENABLE_CLEAR_ADDR
      && i_wdata[21:0] == 22'h3F3F3F |=> !o_irq) else $error("interrupt with all masks cleared");
endmodule
bind dma_sw_request_irq_ctrl dma_sw_request_irq_ctrl_chk chk_i (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_write_protect_on, .o_controller_enable, .o_single_req, .o_burst_req,
   .o_final_mark, .i_buffer_done_evt, .o_irq);

// >>> tb/testbench.sv
// Self-checking bench for the DMA request and interrupt mask block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] EN = dma_ctrl_pkg::CONTROLLER_ENABLE_ADDR;
   localparam logic [31:0] SR = dma_ctrl_pkg::SW_SINGLE_REQUEST_ADDR;
   localparam logic [31:0] CR = dma_ctrl_pkg::SW_CHUNK_REQUEST_ADDR;
   localparam logic [31:0] FL = dma_ctrl_pkg::SW_FINAL_FLAG_ADDR;
   localparam logic [31:0] ST = dma_ctrl_pkg::IRQ_ENABLE_SET_ADDR;
   localparam logic [31:0] CL = dma_ctrl_pkg::IRQ_ENABLE_CLEAR_ADDR;
   localparam logic [31:0] MK = dma_ctrl_pkg::IRQ_MASK_VIEW_ADDR;
   localparam logic [31:0] SS = dma_ctrl_pkg::IRQ_EVENT_STATUS_ADDR;
   logic        i_sys_clk, i_reset_n, i_wr, i_rd, i_write_protect_on, o_controller_enable, o_irq;
   logic [31:0] i_addr, i_wdata, o_rdata;
   logic [11:0] i_single_ack, i_burst_ack, o_single_req, o_burst_req, o_final_mark;
   logic [5:0]  i_buffer_done_evt, i_chain_done_evt, i_bus_fault_evt;
   int          n_errors = 0;
   int          n_tests = 0;
   dma_sw_request_irq_ctrl DUT (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_write_protect_on, .o_controller_enable, .o_single_req, .o_burst_req, .o_final_mark,
      .i_single_ack, .i_burst_ack, .i_buffer_done_evt, .i_chain_done_evt, .i_bus_fault_evt, .o_irq);
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [31:0] a, logic [31:0] e);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, o_rdata);
   endtask
   // Order: buffer, chain, fault events, single acks, chunk acks
   task automatic pulse(logic [41:0] v);
      @(posedge i_sys_clk);
      {i_buffer_done_evt, i_chain_done_evt, i_bus_fault_evt, i_single_ack, i_burst_ack} <= v;
      @(posedge i_sys_clk);
      {i_buffer_done_evt, i_chain_done_evt, i_bus_fault_evt, i_single_ack, i_burst_ack} <= '0;
      #1;
   endtask
   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #50000;
      n_errors++;
      conclude();
   end
   initial begin
      i_reset_n = 1'b0;
      {i_wr, i_rd, i_addr, i_wdata} = '0;
      i_write_protect_on = 1'b1;
      {i_buffer_done_evt, i_chain_done_evt, i_bus_fault_evt, i_single_ack, i_burst_ack} = '0;
      repeat (5) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      for (logic [31:0] a = EN; a <= SS; a += 32'h4) rd(a, 32'h0);
      wr(EN, 32'h1);
      chk("enable", 32'h0, 32'(o_controller_enable));
      @(posedge i_sys_clk) i_write_protect_on <= 1'b0;
      wr(EN, 32'h1);
      chk("enable", 32'h1, 32'(o_controller_enable));
      wr(FL, 32'h802);
      chk("final", 32'h802, 32'(o_final_mark));
      wr(SR, 32'hFFF);
      chk("single", 32'hFFF, 32'(o_single_req));
      wr(SR, 32'h0);
      rd(SR, 32'hFFF);
      pulse(42'h000002000);
      chk("single", 32'hFFD, 32'(o_single_req));
      chk("final", 32'h800, 32'(o_final_mark));
      wr(CR, 32'h801);
      chk("chunk", 32'h801, 32'(o_burst_req));
      pulse(42'h000000FFF);
      chk("chunk", 32'h0, 32'(o_burst_req));
      chk("final", 32'h0, 32'(o_final_mark));
      wr(EN, 32'h0);
      chk("single", 32'h0, 32'(o_single_req));
      rd(SR, 32'hFFD);
      @(posedge i_sys_clk) i_buffer_done_evt <= 6'h01;
      wr(ST, 32'h3F3F3F);
      @(posedge i_sys_clk) i_buffer_done_evt <= 6'h00;
      #1;
      chk("irq", 32'h1, 32'(o_irq));
      rd(SS, 32'h1);
      chk("irq", 32'h0, 32'(o_irq));
      wr(CL, 32'h010101);
      rd(MK, 32'h3E3E3E);
      pulse(42'h0060000000);
      chk("irq", 32'h1, 32'(o_irq));
      rd(SS, 32'h200100);
      pulse(42'h0080000000);
      chk("irq", 32'h1, 32'(o_irq));
      rd(SS, 32'h200);
      wr(MK, 32'h0);
      rd(MK, 32'h3E3E3E);
      wr(CL, 32'h3F3F3F);
      pulse(42'h3FFFF000000);
      chk("irq", 32'h0, 32'(o_irq));
      wr(EN, 32'h1);
      wr(ST, 32'h3F3F3F);
      chk("irq", 32'h1, 32'(o_irq));
      // Second reset in mid-run: all state back to zero
      @(posedge i_sys_clk) i_reset_n <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      chk("enable", 32'h0, 32'(o_controller_enable));
      chk("irq", 32'h0, 32'(o_irq));
      rd(MK, 32'h0);
      rd(SR, 32'h0);
      rd(SS, 32'h0);
      conclude();
   end
endmodule
